/* File: scb_pkg.sv */
// Shared constants and helpers for the SMBus register access bridge
package scb_pkg;
   localparam int SCB_MCLK_NS = 5;
   localparam int SCB_QTR_NS = 40;
   localparam int SCB_QTR_CYC = (SCB_QTR_NS + SCB_MCLK_NS - 1) / SCB_MCLK_NS;
   // Slave address, value is arbitrary
   localparam logic [6:0] SCB_SLAVE_ADDR = 7'h5A;
   // Command code field positions
   localparam int CC_END = 0;
   localparam int CC_START = 1;
   localparam int CC_FUNC_LSB = 2;
   localparam int CC_SIZE_LSB = 5;
   localparam int CC_PEC = 7;
   localparam logic [2:0] SCB_FUNC_REG = 3'h0;
   localparam logic [1:0] SCB_SIZE_BYTE = 2'h0;
   localparam logic [1:0] SCB_SIZE_WORD = 2'h1;
   localparam logic [1:0] SCB_SIZE_BLOCK = 2'h2;
   localparam logic [1:0] SCB_SIZE_RSVD = 2'h3;
   // Command byte field positions
   localparam int CMD_RNW = 4;
   localparam int CMD_RSV = 5;
   localparam int CMD_RD_FLAG = 6;
   localparam int CMD_WR_FLAG = 7;
   localparam int SCB_AH_BITS = 6;
   // Buffer holds command byte, address low/high and four data bytes
   localparam logic [2:0] SCB_BUF_LEN = 3'h7;
   localparam logic [7:0] SCB_CNT_SETUP = 8'h03;
   localparam logic [7:0] SCB_CNT_FULL = 8'h07;
   localparam logic [7:0] SCB_CRC_POLY = 8'h07;
   localparam logic [7:0] SCB_CRC_INIT = 8'h00;

   function automatic logic [7:0] scb_crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ SCB_CRC_POLY) : (r << 1);
      end
      return r;
   endfunction
endpackage

/* File: scb_link_if.sv */
// Two-wire link between the SMBus master end and the device end
`timescale 1ns/1ps
interface scb_link_if;
   logic scl;
   logic sda_h_o;
   logic sda_h_oe;
   logic sda_d_o;
   logic sda_d_oe;
   logic sda;
   // Open-drain data wire with pull-up
   assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));
   modport host (output scl, output sda_h_o, output sda_h_oe, input sda);
   modport dev (input scl, input sda, output sda_d_o, output sda_d_oe);
endinterface

/* File: scb_dev.sv */
// Device end: SMBus slave turning transfers into internal register accesses
`timescale 1ns/1ps
// Overview of operation
// RULE1: Byte order: code, count, command, address, data
// RULE2: Count byte only in block transfers
// RULE3: Master counts bytes following the count
// RULE4: Block read data preceded by count incl status
// RULE5: Count excludes trailing error-check byte
// RULE6: Address low byte is register address[7:0]
// RULE7: High byte gives six bits; top two ignored
// RULE8: Data bytes least significant first
// RULE9: Command bits 3:0 are byte-lane enables
// RULE10: Command bit 4: zero write, one read
// RULE11: Master sends command bit 5 zero
// RULE12: Bit 6 flags unclaimed read, clears on read
// RULE13: Bit 7 flags unclaimed write, clears on read
// RULE14: Clear flag means claimed, not error-free
// RULE15: Function field zero selects register access
// RULE16: Size field and error-check enable bit
// RULE17: Start and end bits frame multi-part sequences
// RULE18: Refuse commands while busy, master retries
// RULE19: Disabled byte lanes stay unchanged on write
module scb_dev
   import scb_pkg::*;
(
   input logic MCLK,
   input logic RESET_N,
   input logic CE,
   scb_link_if.dev LNK,
   output logic REG_REQ,
   output logic REG_WE,
   output logic [13:0] REG_ADDR,
   output logic [3:0] REG_BE,
   output logic [31:0] REG_WDATA,
   input logic [31:0] REG_RDATA,
   input logic REG_ACK,
   input logic REG_CLAIMED
);
   typedef enum logic [4:0] {
      D_IDLE = 5'b00001,
      D_RX = 5'b00010,
      D_ACK = 5'b00100,
      D_TX = 5'b01000,
      D_RACK = 5'b10000
   } scb_dst_e;

   scb_dst_e state_r;
   logic [2:0] scl_q_r;
   logic [2:0] sda_q_r;
   logic scl_s_r;
   logic sda_s_r;
   logic [3:0] bit_r;
   logic [7:0] sh_r;
   logic [3:0] bidx_r;
   logic rd_r;
   logic mack_r;
   logic oe_r;
   logic [7:0] code_r;
   logic [7:0] cnt_r;
   logic [2:0] wptr_r;
   logic [2:0] rptr_r;
   logic tpos_r;
   logic wrote_r;
   logic in_txn_r;
   logic [7:0] crc_r;
   logic rd_flag_r;
   logic wr_flag_r;
   logic [7:0] buf_r [0:6];

   // Edge and condition detection on the synchronised pins
   wire scl_chg = (scl_q_r[1] == scl_q_r[2]) && (scl_q_r[2] != scl_s_r);
   wire sda_chg = (sda_q_r[1] == sda_q_r[2]) && (sda_q_r[2] != sda_s_r);
   wire rise = scl_chg & scl_q_r[2];
   wire fall = scl_chg & ~scl_q_r[2];
   wire start_c = sda_chg & ~sda_q_r[2] & scl_s_r;
   wire stop_c = sda_chg & sda_q_r[2] & scl_s_r;

   // Received byte decode
   wire [1:0] cc_size = code_r[CC_SIZE_LSB +: 2];
   wire blk = (cc_size == SCB_SIZE_BLOCK);
   wire is_adr = (bidx_r == 4'h0);
   wire is_cc = (bidx_r == 4'h1);
   wire adr_ok = (sh_r[7:1] == SCB_SLAVE_ADDR) && !REG_REQ; // [RULE18]
   wire [2:0] new_func = sh_r[CC_FUNC_LSB +: 3];
   wire [1:0] new_size = sh_r[CC_SIZE_LSB +: 2];
   wire cc_ok = (new_func == SCB_FUNC_REG) && (new_size != SCB_SIZE_RSVD); // [RULE15] [RULE16]
   wire rx_ack = is_adr ? adr_ok : (is_cc ? cc_ok : 1'b1);
   wire [3:0] ppos = bidx_r - 4'h2;
   wire cnt_pos = blk && (ppos == 4'h0); // [RULE2]
   wire [3:0] dpos = blk ? ppos - 4'h1 : ppos; // [RULE1]
   wire [7:0] dlim = blk ? cnt_r : ((cc_size == SCB_SIZE_WORD) ? 8'h02 : 8'h01);
   // Bytes past the count (the error-check byte) are not stored
   wire in_lim = ({4'h0, dpos} < dlim); // [RULE5]
   wire store = !is_adr && !is_cc && !cnt_pos && in_lim && (wptr_r < SCB_BUF_LEN);
   wire byte_done = (state_r == D_RX) && fall && (bit_r == 4'h8);
   wire byte_ok = byte_done && rx_ack;

   // Transmit byte selection
   wire load = fall && (((state_r == D_ACK) && rd_r) || ((state_r == D_RACK) && mack_r));
   wire cnt_slot = blk && !tpos_r;
   wire [7:0] cnt_b = {5'h00, SCB_BUF_LEN - rptr_r}; // [RULE4] [RULE5]
   wire [7:0] cmd_b = {wr_flag_r, rd_flag_r, buf_r[0][5:0]}; // [RULE12] [RULE13]
   wire [7:0] dat_b = (rptr_r < SCB_BUF_LEN) ? buf_r[rptr_r] : crc_r;
   wire [7:0] txb = cnt_slot ? cnt_b : ((rptr_r == 3'h0) ? cmd_b : dat_b);
   wire flag_clr = load && !cnt_slot && (rptr_r == 3'h0); // [RULE12] [RULE13]

   // Register access launch and completion
   wire exec = stop_c && wrote_r && code_r[CC_END] && !REG_REQ; // [RULE17]
   wire done = REG_REQ && REG_ACK;
   // Flags report only whether a target claimed the access
   wire set_r = done && !REG_WE && !REG_CLAIMED; // [RULE12] [RULE14]
   wire set_w = done && REG_WE && !REG_CLAIMED; // [RULE13] [RULE14]

   assign LNK.sda_d_o = 1'b0;
   assign LNK.sda_d_oe = oe_r;

   // Pin synchronisers
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         scl_q_r <= 3'h7;
         sda_q_r <= 3'h7;
         scl_s_r <= 1'b1;
         sda_s_r <= 1'b1;
      end else if (CE) begin
         scl_q_r <= {scl_q_r[1:0], LNK.scl};
         sda_q_r <= {sda_q_r[1:0], LNK.sda};
         if (scl_chg) scl_s_r <= scl_q_r[2];
         if (sda_chg) sda_s_r <= sda_q_r[2];
      end
   end

   // Bit engine
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         state_r <= D_IDLE;
         bit_r <= 4'h0;
         sh_r <= 8'h00;
         bidx_r <= 4'h0;
         rd_r <= 1'b0;
         mack_r <= 1'b0;
         oe_r <= 1'b0;
      end else if (CE) begin
         if (start_c) begin
            state_r <= D_RX;
            bit_r <= 4'h0;
            bidx_r <= 4'h0;
            rd_r <= 1'b0;
            oe_r <= 1'b0;
         end else if (stop_c) begin
            state_r <= D_IDLE;
            oe_r <= 1'b0;
         end else if (load) begin
            oe_r <= ~txb[7];
            sh_r <= {txb[6:0], 1'b1};
            bit_r <= 4'h1;
            state_r <= D_TX;
         end else begin
            case (state_r)
               D_IDLE: oe_r <= 1'b0;
               D_RX: begin
                  if (rise) begin
                     sh_r <= {sh_r[6:0], sda_s_r};
                     bit_r <= bit_r + 4'h1;
                  end else if (byte_done) begin
                     oe_r <= rx_ack; // [RULE18]
                     state_r <= rx_ack ? D_ACK : D_IDLE;
                     if (is_adr) rd_r <= sh_r[0];
                  end
               end
               D_ACK: begin
                  if (fall) begin
                     oe_r <= 1'b0;
                     bit_r <= 4'h0;
                     bidx_r <= (bidx_r == 4'hF) ? bidx_r : bidx_r + 4'h1;
                     state_r <= D_RX;
                  end
               end
               D_TX: begin
                  if (fall) begin
                     if (bit_r == 4'h8) begin
                        oe_r <= 1'b0;
                        state_r <= D_RACK;
                     end else begin
                        oe_r <= ~sh_r[7];
                        sh_r <= {sh_r[6:0], 1'b1};
                        bit_r <= bit_r + 4'h1;
                     end
                  end
               end
               D_RACK: begin
                  if (rise) mack_r <= ~sda_s_r;
                  else if (fall) state_r <= D_IDLE;
               end
               default: state_r <= D_IDLE;
            endcase
         end
      end
   end

   // Transfer bookkeeping, buffer and flags
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         code_r <= 8'h00;
         cnt_r <= 8'h00;
         wptr_r <= 3'h0;
         rptr_r <= 3'h0;
         tpos_r <= 1'b0;
         wrote_r <= 1'b0;
         in_txn_r <= 1'b0;
         crc_r <= SCB_CRC_INIT;
         rd_flag_r <= 1'b0;
         wr_flag_r <= 1'b0;
         for (int i = 0; i < 7; i++) buf_r[i] <= 8'h00;
      end else if (CE) begin
         rd_flag_r <= (rd_flag_r & ~flag_clr) | set_r;
         wr_flag_r <= (wr_flag_r & ~flag_clr) | set_w;
         if (start_c) begin
            if (!in_txn_r) crc_r <= SCB_CRC_INIT;
            in_txn_r <= 1'b1;
            tpos_r <= 1'b0;
            wrote_r <= 1'b0;
         end else if (stop_c) begin
            in_txn_r <= 1'b0;
         end else if (byte_ok) begin
            crc_r <= scb_crc8(crc_r, sh_r);
            if (is_cc) begin
               code_r <= sh_r;
               if (sh_r[CC_START]) begin // [RULE17]
                  wptr_r <= 3'h0;
                  rptr_r <= 3'h0;
               end
            end
            if (!is_adr && !is_cc && cnt_pos) cnt_r <= sh_r;
            if (store) begin
               buf_r[wptr_r] <= sh_r; // [RULE1]
               wptr_r <= wptr_r + 3'h1;
               wrote_r <= 1'b1;
            end
         end else if (load) begin
            crc_r <= scb_crc8(crc_r, txb);
            if (cnt_slot) tpos_r <= 1'b1;
            else if (rptr_r < SCB_BUF_LEN) rptr_r <= rptr_r + 3'h1;
         end
         if (done && !REG_WE) begin
            for (int i = 0; i < 4; i++) buf_r[3 + i] <= REG_RDATA[8 * i +: 8]; // [RULE8]
         end
      end
   end

   // Internal register request
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         REG_REQ <= 1'b0;
         REG_WE <= 1'b0;
         REG_ADDR <= 14'h0000;
         REG_BE <= 4'h0;
         REG_WDATA <= 32'h0000_0000;
      end else if (CE) begin
         if (exec) begin
            REG_REQ <= 1'b1;
            REG_WE <= ~buf_r[0][CMD_RNW]; // [RULE10]
            REG_ADDR <= {buf_r[2][SCB_AH_BITS-1:0], buf_r[1]}; // [RULE6] [RULE7]
            REG_BE <= buf_r[0][3:0]; // [RULE9] [RULE19]
            REG_WDATA <= {buf_r[6], buf_r[5], buf_r[4], buf_r[3]}; // [RULE8]
         end else if (done) begin
            REG_REQ <= 1'b0;
         end
      end
   end
endmodule // scb_dev

/* File: scb_host.sv */
// Master end: issues block register write and read sequences on the link
`timescale 1ns/1ps
module scb_host
   import scb_pkg::*;
(
   input logic MCLK,
   input logic RESET_N,
   input logic CE,
   scb_link_if.host LNK,
   input logic REQ_VALID,
   output logic REQ_READY,
   input logic REQ_RNW,
   input logic REQ_PEC,
   input logic [13:0] REQ_ADDR,
   input logic [3:0] REQ_BE,
   input logic [31:0] REQ_WDATA,
   output logic RSP_VALID,
   output logic [31:0] RSP_DATA,
   output logic [7:0] RSP_STATUS
);
   typedef enum logic [3:0] {
      H_IDLE = 4'b0001,
      H_START = 4'b0010,
      H_BIT = 4'b0100,
      H_STOP = 4'b1000
   } scb_hst_e;

   scb_hst_e state_r;
   logic [2:0] sda_q_r;
   logic sda_s_r;
   logic scl_r;
   logic oe_r;
   logic [7:0] qcnt_r;
   logic [1:0] q_r;
   logic ph_r;
   logic [3:0] idx_r;
   logic [3:0] bit_r;
   logic [7:0] sh_r;
   logic nak_r;
   logic retry_r;
   logic [7:0] crc_r;
   logic rnw_r;
   logic pec_r;
   logic [13:0] addr_r;
   logic [3:0] be_r;
   logic [31:0] wd_r;
   logic [7:0] tbl_b;

   wire tick = (qcnt_r == 8'h00);
   wire sda_chg = (sda_q_r[1] == sda_q_r[2]) && (sda_q_r[2] != sda_s_r);
   wire [7:0] cc_b = {pec_r, SCB_SIZE_BLOCK, SCB_FUNC_REG, 2'h3}; // [RULE15] [RULE16] [RULE17]
   wire [7:0] cmd_b = {2'b00, 1'b0, rnw_r, be_r}; // [RULE9] [RULE10] [RULE11]
   wire [7:0] cnt_b = rnw_r ? SCB_CNT_SETUP : SCB_CNT_FULL; // [RULE3] [RULE5]
   wire [3:0] wlast = rnw_r ? 4'h5 : 4'h9;
   wire [3:0] plast = ph_r ? (pec_r ? 4'hB : 4'hA) : (pec_r ? wlast + 4'h1 : wlast);
   wire rx_byte = ph_r && (idx_r >= 4'h3);
   wire pec_slot = !ph_r && (idx_r > wlast);
   wire [7:0] hb = pec_slot ? crc_r : tbl_b; // [RULE5]
   wire last = (idx_r == plast);

   // Outgoing byte by position
   always_comb begin
      case (idx_r)
         4'h0: tbl_b = {SCB_SLAVE_ADDR, 1'b0};
         4'h1: tbl_b = cc_b; // [RULE1]
         4'h2: tbl_b = ph_r ? {SCB_SLAVE_ADDR, 1'b1} : cnt_b; // [RULE2]
         4'h3: tbl_b = cmd_b;
         4'h4: tbl_b = addr_r[7:0]; // [RULE6]
         4'h5: tbl_b = {2'b00, addr_r[13:8]}; // [RULE7]
         4'h6: tbl_b = wd_r[7:0]; // [RULE8]
         4'h7: tbl_b = wd_r[15:8];
         4'h8: tbl_b = wd_r[23:16];
         4'h9: tbl_b = wd_r[31:24];
         default: tbl_b = 8'hFF;
      endcase
   end

   assign LNK.scl = scl_r;
   assign LNK.sda_h_o = 1'b0;
   assign LNK.sda_h_oe = oe_r;

   // Data pin synchroniser and quarter-bit timer
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         sda_q_r <= 3'h7;
         sda_s_r <= 1'b1;
         qcnt_r <= 8'h00;
      end else if (CE) begin
         sda_q_r <= {sda_q_r[1:0], LNK.sda};
         if (sda_chg) sda_s_r <= sda_q_r[2];
         if (state_r == H_IDLE || tick) qcnt_r <= 8'(SCB_QTR_CYC - 1);
         else qcnt_r <= qcnt_r - 8'h01;
      end
   end

   // Sequencer
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         state_r <= H_IDLE;
         REQ_READY <= 1'b1;
         RSP_VALID <= 1'b0;
         RSP_DATA <= 32'h0000_0000;
         RSP_STATUS <= 8'h00;
         scl_r <= 1'b1;
         oe_r <= 1'b0;
         q_r <= 2'h0;
         ph_r <= 1'b0;
         idx_r <= 4'h0;
         bit_r <= 4'h0;
         sh_r <= 8'h00;
         nak_r <= 1'b0;
         retry_r <= 1'b0;
         crc_r <= SCB_CRC_INIT;
         rnw_r <= 1'b0;
         pec_r <= 1'b0;
         addr_r <= 14'h0000;
         be_r <= 4'h0;
         wd_r <= 32'h0000_0000;
      end else if (CE) begin
         RSP_VALID <= 1'b0;
         if (state_r == H_IDLE) begin
            if (REQ_VALID && REQ_READY) begin
               REQ_READY <= 1'b0;
               rnw_r <= REQ_RNW;
               pec_r <= REQ_PEC;
               addr_r <= REQ_ADDR;
               be_r <= REQ_BE;
               wd_r <= REQ_WDATA;
               ph_r <= 1'b0;
               idx_r <= 4'h0;
               q_r <= 2'h0;
               state_r <= H_START;
            end
         end else if (tick) begin
            q_r <= q_r + 2'h1;
            case (state_r)
               H_START: begin
                  case (q_r)
                     2'h0: oe_r <= 1'b0;
                     2'h1: scl_r <= 1'b1;
                     2'h2: oe_r <= 1'b1;
                     default: begin
                        scl_r <= 1'b0;
                        bit_r <= 4'h0;
                        if (idx_r == 4'h0) crc_r <= SCB_CRC_INIT;
                        state_r <= H_BIT;
                     end
                  endcase
               end
               H_BIT: begin
                  case (q_r)
                     2'h0: begin
                        if (bit_r == 4'h8) oe_r <= rx_byte && !last;
                        else if (bit_r == 4'h0) oe_r <= !rx_byte && !hb[7];
                        else oe_r <= !rx_byte && !sh_r[7];
                        if (bit_r == 4'h0) sh_r <= hb;
                     end
                     2'h1: scl_r <= 1'b1;
                     2'h2: begin
                        if (bit_r == 4'h8) nak_r <= sda_s_r;
                        else sh_r <= {sh_r[6:0], sda_s_r};
                     end
                     default: begin
                        scl_r <= 1'b0;
                        if (bit_r != 4'h8) begin
                           bit_r <= bit_r + 4'h1;
                        end else begin
                           crc_r <= scb_crc8(crc_r, sh_r);
                           bit_r <= 4'h0;
                           if (rx_byte && idx_r == 4'h4) RSP_STATUS <= sh_r;
                           if (rx_byte && idx_r >= 4'h7 && idx_r <= 4'hA) begin
                              RSP_DATA <= {sh_r, RSP_DATA[31:8]}; // [RULE8]
                           end
                           if (!rx_byte && nak_r) begin
                              retry_r <= 1'b1; // [RULE18]
                              state_r <= H_STOP;
                           end else if (last) begin
                              state_r <= H_STOP;
                           end else if (ph_r && idx_r == 4'h1) begin
                              idx_r <= 4'h2;
                              state_r <= H_START;
                           end else begin
                              idx_r <= idx_r + 4'h1;
                           end
                        end
                     end
                  endcase
               end
               H_STOP: begin
                  case (q_r)
                     2'h0: oe_r <= 1'b1;
                     2'h1: scl_r <= 1'b1;
                     2'h2: oe_r <= 1'b0;
                     default: begin
                        idx_r <= 4'h0;
                        if (retry_r) begin
                           retry_r <= 1'b0;
                           state_r <= H_START;
                        end else if (!ph_r && rnw_r) begin
                           ph_r <= 1'b1;
                           state_r <= H_START;
                        end else begin
                           RSP_VALID <= 1'b1;
                           REQ_READY <= 1'b1;
                           state_r <= H_IDLE;
                        end
                     end
                  endcase
               end
               default: state_r <= H_IDLE;
            endcase
         end
      end
   end
endmodule // scb_host

/* File: scb_link_props.sv */
// Checker of the two-wire link between host and device ends
`timescale 1ns/1ps
module scb_link_props (
   input logic MCLK,
   input logic RESET_N,
   input logic scl,
   input logic sda_h_o,
   input logic sda_h_oe,
   input logic sda_d_o,
   input logic sda_d_oe,
   input logic sda
);
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RESET_N);

   // Start and stop conditions
   sequence start_s;
      scl && $fell(sda);
   endsequence
   sequence stop_s;
      scl && $rose(sda);
   endsequence

   AST_SCL_HIGH_HOLD: assert property ($rose(scl) |=> scl [*8])
      else $error("clock high phase too short");
   AST_SCL_LOW_HOLD: assert property ($fell(scl) |=> !scl [*8])
      else $error("clock low phase too short");
   AST_SCL_LOW_BOUND: assert property ($fell(scl) |-> ##[8:24] scl)
      else $error("clock low phase too long");
   AST_DEV_EDGE_LOW: assert property ($changed(sda_d_oe) |-> !scl)
      else $error("device data changed while clock high");
   AST_DEV_HOLD: assert property ($rose(sda_d_oe) |=> sda_d_oe [*8])
      else $error("device drive released too early");
   AST_OPEN_DRAIN: assert property (!sda_h_o && !sda_d_o)
      else $error("data line driven high");
   AST_START_FALL: assert property (start_s |-> ##[1:16] !scl)
      else $error("no clock after start");
   AST_STOP_IDLE: assert property (stop_s |=> scl [*8])
      else $error("clock moved right after stop");
endmodule // scb_link_props

/* File: tb.sv */
// Bench joining both ends of the register access bridge
`timescale 1ns/1ps
module tb;
   import scb_pkg::*;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic req_valid = 1'b0;
   logic req_rnw = 1'b0;
   logic req_pec = 1'b0;
   logic [13:0] req_addr = '0;
   logic [3:0] req_be = '0;
   logic [31:0] req_wdata = '0;
   logic req_ready;
   logic rsp_valid;
   logic [31:0] rsp_data;
   logic [7:0] rsp_status;
   logic reg_req;
   logic reg_we;
   logic [13:0] reg_addr;
   logic [3:0] reg_be;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata = '0;
   logic reg_ack = 1'b0;
   logic reg_claimed = 1'b0;
   logic [31:0] mem [0:15];
   logic [31:0] last_wd;
   logic [13:0] last_addr;
   logic [3:0] last_be;
   logic last_we;
   int ack_dly = 2;
   int cnt = 0;
   int cyc = 0;
   int bad_count = 0;
   int checked = 0;

   scb_link_if lnk();

   always #2.5 mclk = ~mclk;

   scb_host i_scb_host (.MCLK(mclk), .RESET_N(reset_n), .CE(1'b1), .LNK(lnk),
      .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_RNW(req_rnw), .REQ_PEC(req_pec),
      .REQ_ADDR(req_addr), .REQ_BE(req_be), .REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid),
      .RSP_DATA(rsp_data), .RSP_STATUS(rsp_status));
   scb_dev i_scb_dev (.MCLK(mclk), .RESET_N(reset_n), .CE(1'b1), .LNK(lnk),
      .REG_REQ(reg_req), .REG_WE(reg_we), .REG_ADDR(reg_addr), .REG_BE(reg_be),
      .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_ACK(reg_ack),
      .REG_CLAIMED(reg_claimed));
   scb_link_props i_scb_link_props (.MCLK(mclk), .RESET_N(reset_n), .scl(lnk.scl),
      .sda_h_o(lnk.sda_h_o), .sda_h_oe(lnk.sda_h_oe), .sda_d_o(lnk.sda_d_o),
      .sda_d_oe(lnk.sda_d_oe), .sda(lnk.sda));

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Internal target: addresses 0 to 15 claimed, disabled lanes kept
   always @(posedge mclk) begin
      #1;
      if (reg_req && !reg_ack && cnt >= ack_dly) begin
         reg_ack = 1'b1;
         reg_claimed = (reg_addr < 14'h0010);
         reg_rdata = mem[reg_addr[3:0]];
         last_addr = reg_addr;
         last_be = reg_be;
         last_we = reg_we;
         last_wd = reg_wdata;
         for (int i = 0; i < 4; i++) begin
            if (reg_we && reg_claimed && reg_be[i]) begin
               mem[reg_addr[3:0]][8*i +: 8] = reg_wdata[8*i +: 8];
            end
         end
      end else begin
         reg_ack = 1'b0;
      end
      cnt = reg_req ? cnt + 1 : 0;
      cyc++;
      if (cyc == 90000) begin
         bad_count++;
         wrap_up();
      end
   end

   // One request through the host end, waits for its response
   task automatic do_req(input logic rnw, input logic pec, input logic [13:0] a,
         input logic [3:0] be, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge mclk);
      #1;
      req_valid = 1'b1;
      req_rnw = rnw;
      req_pec = pec;
      req_addr = a;
      req_be = be;
      req_wdata = wd;
      @(posedge mclk);
      #1;
      req_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 30000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk("rsp_valid", 32'(rsp_valid), 32'h1);
   endtask

   // Partial lane write with error check byte, then read back
   task automatic t_lanes;
      do_req(1'b0, 1'b0, 14'h0003, 4'hF, 32'hA5A5A5A5);
      do_req(1'b0, 1'b1, 14'h0003, 4'h5, 32'h12345678);
      chk("reg_we", 32'(last_we), 32'h1);
      chk("reg_addr", 32'(last_addr), 32'h3);
      chk("reg_be", 32'(last_be), 32'h5);
      chk("reg_wdata", last_wd, 32'h12345678);
      do_req(1'b1, 1'b0, 14'h0003, 4'hF, 32'h0);
      chk("reg_we", 32'(last_we), 32'h0);
      chk("rsp_data", rsp_data, 32'hA534A578);
      chk("flags", 32'(rsp_status[7:6]), 32'h0);
      chk("status", 32'(rsp_status[5:0]), 32'h1F);
      chk("req_ready", 32'(req_ready), 32'h1);
   endtask

   // Unclaimed write and read flags, cleared once returned
   task automatic t_unclaimed;
      do_req(1'b0, 1'b0, 14'h2A51, 4'hF, 32'hDEADBEEF);
      chk("reg_addr", 32'(last_addr), 32'h2A51);
      do_req(1'b1, 1'b0, 14'h0003, 4'hF, 32'h0);
      chk("flags", 32'(rsp_status[7:6]), 32'h2);
      do_req(1'b1, 1'b1, 14'h3F00, 4'hF, 32'h0);
      chk("flags", 32'(rsp_status[7:6]), 32'h1);
      do_req(1'b1, 1'b0, 14'h0003, 4'hF, 32'h0);
      chk("flags", 32'(rsp_status[7:6]), 32'h0);
   endtask

   // Slow target keeps device busy, host must retry
   task automatic t_busy;
      ack_dly = 900;
      do_req(1'b0, 1'b0, 14'h0007, 4'hF, 32'h0BADF00D);
      do_req(1'b1, 1'b1, 14'h0007, 4'hF, 32'h0);
      chk("rsp_data", rsp_data, 32'h0BADF00D);
      ack_dly = 2;
   endtask

   initial begin
      foreach (mem[i]) begin
         mem[i] = '0;
      end
      repeat (8) @(posedge mclk);
      #1;
      reset_n = 1'b1;
      t_lanes();
      t_unclaimed();
      t_busy();
      wrap_up();
   end
endmodule // tb
